// ===== sector_flash_program_control.sv
// host controller that reads, programs sectors and sends commands to a parallel flash
//
// What this block does
// - during sector loads drive the sector number on the sector number lines.
// - load all 128 bytes of the sector, none skipped.
// - start each byte load within the byte load window, else abort.
// - poll until two consecutive toggle status bits match; assume no start value.
// - poll at one fixed address, the sector base.
`timescale 1ns/1ps
module sector_flash_program_control
#(
    parameter int BLC_LIMIT = flash_host_pkg::BLC_CYC - flash_host_pkg::BLC_MARGIN,
    parameter int WC_LIMIT  = flash_host_pkg::WC_CYC
)
(
    // clock and reset
    input  wire logic                                ref_clk,
    input  wire logic                                rstn,
    // command port
    input  wire logic                                cmd_valid,
    output logic                                     cmd_ready,
    input  wire flash_host_pkg::op_e                 cmd_op,
    input  wire logic [flash_host_pkg::ADDR_W-1:0]   cmd_addr,
    // sector byte stream
    input  wire logic                                byte_valid,
    output logic                                     byte_ready,
    input  wire logic [flash_host_pkg::DATA_W-1:0]   byte_data,
    // response
    output logic                                     rsp_valid,
    output logic                                     rsp_error,
    output logic      [flash_host_pkg::DATA_W-1:0]   rsp_data,
    // flash pins
    output logic      [flash_host_pkg::ADDR_W-1:0]   flash_addr,
    output logic                                     flash_ce_n,
    output logic                                     flash_oe_n,
    output logic                                     flash_we_n,
    output logic      [flash_host_pkg::DATA_W-1:0]   flash_dq_out,
    output logic                                     flash_dq_oe_n,
    input  wire logic [flash_host_pkg::DATA_W-1:0]   flash_dq_in
);
    import flash_host_pkg::*;

    localparam int WIN_W     = $clog2(BLC_LIMIT + 1);
    // device only starts programming once its load window has run out
    localparam int POLL_WAIT = BLC_LIMIT + BLC_MARGIN;
    localparam int WC_W      = $clog2(WC_LIMIT + POLL_WAIT + 1);
    localparam logic [7:0] LAST_BYTE = 8'(SECTOR_BYTES - 1);

    if (BLC_LIMIT < 1 || BLC_LIMIT > BLC_CYC || WC_LIMIT < 1) begin : g_chk
        $error("byte load or program timeout out of range");
    end

    typedef enum logic [4:0] {
        S_IDLE = 5'b00001,
        S_READ = 5'b00010,
        S_CMD  = 5'b00100,
        S_LOAD = 5'b01000,
        S_POLL = 5'b10000
    } state_e;

    function automatic logic [2:0] seq_len(input op_e op);
        seq_len = (op == OP_LOCK_LOW || op == OP_LOCK_HIGH) ? LONG_SEQ : SHORT_SEQ;
    endfunction

    function automatic logic [CMD_ADDR_W-1:0] seq_addr(input logic [2:0] i);
        seq_addr = (i == 3'h1 || i == 3'h4) ? UNLOCK_ADDR2 : UNLOCK_ADDR1;
    endfunction

    function automatic logic [DATA_W-1:0] seq_data(input op_e op, input logic [2:0] i);
        unique case (i)
            3'h0, 3'h3: seq_data = UNLOCK_DATA1;
            3'h1, 3'h4: seq_data = UNLOCK_DATA2;
            3'h2:
                unique case (op)
                    OP_PROGRAM:  seq_data = CODE_PROGRAM;
                    OP_ID_ENTER: seq_data = CODE_ID_IN;
                    OP_ID_EXIT:  seq_data = CODE_ID_OUT;
                    default:     seq_data = CODE_LOCK;
                endcase
            default: seq_data = (op == OP_LOCK_HIGH) ? CODE_LOCK_HI : CODE_LOCK_LO;
        endcase
    endfunction

    state_e                 state, next_state;
    op_e                    op, next_op;
    logic [ADDR_W-1:0]      base, next_base;
    logic [2:0]             idx, next_idx;
    logic [7:0]             byte_cnt, next_byte_cnt;
    logic [WIN_W-1:0]       win_cnt, next_win_cnt;
    logic [WC_W-1:0]        wc_cnt, next_wc_cnt;
    logic                   prev_tog, next_prev_tog;
    logic                   have_prev, next_have_prev;
    logic                   inflight, next_inflight;
    logic                   next_rsp_valid, next_rsp_error;
    logic [DATA_W-1:0]      next_rsp_data;

    logic                   bus_go, bus_write, bus_idle, bus_done;
    logic [ADDR_W-1:0]      bus_addr;
    logic [DATA_W-1:0]      bus_wdata, bus_rdata;
    logic                   win_over, wc_over;

    assign cmd_ready  = (state == S_IDLE);
    assign win_over   = (win_cnt >= WIN_W'(BLC_LIMIT));
    assign wc_over    = (wc_cnt >= WC_W'(WC_LIMIT + POLL_WAIT));
    assign byte_ready = (state == S_LOAD) && !inflight && bus_idle && !win_over;

    always_comb
    begin
        next_state     = state;
        next_op        = op;
        next_base      = base;
        next_idx       = idx;
        next_byte_cnt  = byte_cnt;
        next_win_cnt   = win_cnt;
        next_wc_cnt    = wc_cnt;
        next_prev_tog  = prev_tog;
        next_have_prev = have_prev;
        next_inflight  = inflight;
        next_rsp_valid = 1'b0;
        next_rsp_error = 1'b0;
        next_rsp_data  = rsp_data;
        bus_go         = 1'b0;
        bus_write      = 1'b0;
        bus_addr       = base;
        bus_wdata      = '0;
        if (bus_done)
            next_inflight = 1'b0;
        unique case (state)
            S_IDLE:
                if (cmd_valid)
                begin
                    next_op   = cmd_op;
                    next_base = cmd_addr;
                    next_idx  = '0;
                    next_state = (cmd_op == OP_READ) ? S_READ : S_CMD;
                end
            S_READ:
            begin
                bus_go = !inflight && bus_idle;
                if (bus_go)
                    next_inflight = 1'b1;
                if (bus_done)
                begin
                    next_rsp_valid = 1'b1;
                    next_rsp_data  = bus_rdata;
                    next_state     = S_IDLE;
                end
            end
            S_CMD:
            begin
                // unlock words go out for every program, the device relocks after each
                bus_write = 1'b1;
                bus_addr  = {base[ADDR_W-1:CMD_ADDR_W], seq_addr(idx)};
                bus_wdata = seq_data(op, idx);
                bus_go    = !inflight && bus_idle;
                if (bus_go)
                    next_inflight = 1'b1;
                if (bus_done)
                begin
                    next_idx = idx + 3'h1;
                    if (idx == seq_len(op) - 3'h1)
                    begin
                        next_byte_cnt = '0;
                        next_win_cnt  = '0;
                        if (op == OP_PROGRAM)
                            next_state = S_LOAD;
                        else
                        begin
                            next_rsp_valid = 1'b1;
                            next_rsp_data  = '0;
                            next_state     = S_IDLE;
                        end
                    end
                end
            end
            S_LOAD:
            begin
                bus_write = 1'b1;
                bus_addr  = {base[ADDR_W-1:SECTOR_LSB], byte_cnt[SECTOR_LSB-1:0]};
                bus_wdata = byte_data;
                bus_go    = byte_valid && byte_ready;
                if (!win_over)
                    next_win_cnt = win_cnt + 1'b1;
                if (bus_go)
                begin
                    next_inflight = 1'b1;
                    next_win_cnt  = '0;
                end
                if (bus_done)
                begin
                    next_byte_cnt = byte_cnt + 8'h1;
                    if (byte_cnt == LAST_BYTE)
                    begin
                        next_state     = S_POLL;
                        next_wc_cnt    = '0;
                        next_have_prev = 1'b0;
                    end
                end
                else if (!inflight && win_over && !bus_go)
                begin
                    // device has begun programming a partial sector
                    next_rsp_valid = 1'b1;
                    next_rsp_error = 1'b1;
                    next_state     = S_IDLE;
                end
            end
            S_POLL:
            begin
                bus_addr = {base[ADDR_W-1:SECTOR_LSB], {SECTOR_LSB{1'b0}}};
                if (!wc_over)
                    next_wc_cnt = wc_cnt + 1'b1;
                // reads inside the load window would see stable data and end the poll early
                bus_go = !inflight && bus_idle && !wc_over && (wc_cnt >= WC_W'(POLL_WAIT));
                if (bus_go)
                    next_inflight = 1'b1;
                if (bus_done)
                begin
                    next_prev_tog  = bus_rdata[TOGGLE_BIT];
                    next_have_prev = 1'b1;
                    if (have_prev && (bus_rdata[TOGGLE_BIT] == prev_tog))
                    begin
                        next_rsp_valid = 1'b1;
                        next_state     = S_IDLE;
                    end
                end
                else if (!inflight && wc_over)
                begin
                    next_rsp_valid = 1'b1;
                    next_rsp_error = 1'b1;
                    next_state     = S_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            state     <= S_IDLE;
            op        <= OP_READ;
            base      <= '0;
            idx       <= '0;
            byte_cnt  <= '0;
            win_cnt   <= '0;
            wc_cnt    <= '0;
            prev_tog  <= 1'b0;
            have_prev <= 1'b0;
            inflight  <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_error <= 1'b0;
            rsp_data  <= '0;
        end
        else
        begin
            state     <= next_state;
            op        <= next_op;
            base      <= next_base;
            idx       <= next_idx;
            byte_cnt  <= next_byte_cnt;
            win_cnt   <= next_win_cnt;
            wc_cnt    <= next_wc_cnt;
            prev_tog  <= next_prev_tog;
            have_prev <= next_have_prev;
            inflight  <= next_inflight;
            rsp_valid <= next_rsp_valid;
            rsp_error <= next_rsp_error;
            rsp_data  <= next_rsp_data;
        end
    end

    flash_bus_cycle u_bus
    (
        .ref_clk       (ref_clk),
        .rstn          (rstn),
        .start         (bus_go),
        .is_write      (bus_write),
        .addr          (bus_addr),
        .wdata         (bus_wdata),
        .idle          (bus_idle),
        .done          (bus_done),
        .rdata         (bus_rdata),
        .flash_addr    (flash_addr),
        .flash_ce_n    (flash_ce_n),
        .flash_oe_n    (flash_oe_n),
        .flash_we_n    (flash_we_n),
        .flash_dq_out  (flash_dq_out),
        .flash_dq_oe_n (flash_dq_oe_n),
        .flash_dq_in   (flash_dq_in)
    );

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    AST_SECTOR_LINES: assert property ((state == S_LOAD) && !flash_we_n |->
                                       flash_addr[ADDR_W-1:SECTOR_LSB] == base[ADDR_W-1:SECTOR_LSB])
        else $error("sector number lines wrong during load");
    AST_FULL_SECTOR: assert property ((state == S_LOAD) && bus_done && (byte_cnt == LAST_BYTE)
                                      |=> (state == S_POLL))
        else $error("poll did not follow the last byte");
    AST_EARLY_POLL: assert property ((state == S_LOAD) && bus_done && (byte_cnt != LAST_BYTE)
                                     |=> (state != S_POLL))
        else $error("poll started before all bytes loaded");
    AST_WINDOW: assert property ((state == S_LOAD) && win_over && !inflight && !bus_go
                                 |=> rsp_valid && rsp_error && (state == S_IDLE))
        else $error("byte load window overrun not reported");
    AST_CMD_ADDR: assert property ((state == S_CMD) && $fell(flash_we_n) |->
                                   flash_addr[CMD_ADDR_W-1:0] == seq_addr(idx))
        else $error("command address wrong");
    AST_TOGGLE_DONE: assert property ((state == S_POLL) && bus_done && have_prev
                                      && (bus_rdata[TOGGLE_BIT] == prev_tog)
                                      |=> rsp_valid && !rsp_error)
        else $error("matching toggle reads did not finish");
    AST_POLL_ADDR: assert property ((state == S_POLL) && !flash_oe_n |->
                                    flash_addr[SECTOR_LSB-1:0] == '0 && $stable(flash_addr))
        else $error("poll address moved");
    AST_WC_TIMEOUT: assert property ((state == S_POLL) && wc_over && !inflight && !bus_done
                                     |=> rsp_valid && rsp_error)
        else $error("program timeout not reported");
    AST_RSP_PULSE: assert property (rsp_valid |=> !rsp_valid ##1 !rsp_valid)
        else $error("response longer than one cycle");

    COV_PROGRAM_OK: cover property ((state == S_POLL) ##1 rsp_valid && !rsp_error);
    COV_READ: cover property ((state == S_READ) ##1 rsp_valid);
    COV_LOCK_HIGH: cover property ((op == OP_LOCK_HIGH) && (state == S_CMD) && (idx == 3'h5) && bus_done);
    COV_WINDOW_ERR: cover property ((state == S_LOAD) ##1 rsp_error);

endmodule

// ===== flash_host_pkg.sv
// constants and types shared by the sector flash host controller
package flash_host_pkg;

    // bus geometry
    localparam int ADDR_W       = 17;
    localparam int DATA_W       = 8;
    localparam int CMD_ADDR_W   = 15;
    localparam int SECTOR_LSB   = 7;
    localparam int SECTOR_BYTES = 128;
    localparam int TOGGLE_BIT   = 6;
    localparam int SYNC_STAGES  = 2;

    // timing, figures as printed
    localparam int CLK_NS    = 20;
    localparam int T_WP_NS   = 200;
    localparam int T_WPH_NS  = 200;
    localparam int T_ACC_NS  = 200;
    localparam int T_OEHP_NS = 150;
    localparam int T_AH_NS   = 100;
    localparam int T_BLC_US  = 150;
    localparam int T_WC_MS   = 20;

    // all times round up except the byte load window, which rounds down
    localparam int WP_CYC   = (T_WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int WPH_CYC  = (T_WPH_NS + CLK_NS - 1) / CLK_NS;
    localparam int ACC_CYC  = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
    localparam int OEHP_CYC = (T_OEHP_NS + CLK_NS - 1) / CLK_NS;
    localparam int AH_CYC   = (T_AH_NS + CLK_NS - 1) / CLK_NS;
    localparam int RD_CYC   = ACC_CYC + SYNC_STAGES + 1;
    localparam int REC_CYC  = (WPH_CYC > OEHP_CYC) ? ((WPH_CYC > AH_CYC) ? WPH_CYC : AH_CYC)
                                                   : ((OEHP_CYC > AH_CYC) ? OEHP_CYC : AH_CYC);
    localparam int BLC_CYC  = (T_BLC_US * 1000) / CLK_NS;
    localparam int WC_CYC   = (T_WC_MS * 1000000 + CLK_NS - 1) / CLK_NS;
    // a byte must be started this many cycles before the load window closes
    localparam int BLC_MARGIN = 64;

    // command sequence words
    localparam logic [CMD_ADDR_W-1:0] UNLOCK_ADDR1 = 15'h5555;
    localparam logic [CMD_ADDR_W-1:0] UNLOCK_ADDR2 = 15'h2aaa;
    localparam logic [DATA_W-1:0]     UNLOCK_DATA1 = 8'haa;
    localparam logic [DATA_W-1:0]     UNLOCK_DATA2 = 8'h55;
    localparam logic [DATA_W-1:0]     CODE_PROGRAM = 8'ha0;
    localparam logic [DATA_W-1:0]     CODE_ID_IN   = 8'h90;
    localparam logic [DATA_W-1:0]     CODE_ID_OUT  = 8'hf0;
    localparam logic [DATA_W-1:0]     CODE_LOCK    = 8'h80;
    localparam logic [DATA_W-1:0]     CODE_LOCK_LO = 8'h40;
    localparam logic [DATA_W-1:0]     CODE_LOCK_HI = 8'h60;
    localparam logic [2:0]            SHORT_SEQ    = 3'h3;
    localparam logic [2:0]            LONG_SEQ     = 3'h6;

    typedef enum logic [2:0] {
        OP_READ      = 3'h0,
        OP_PROGRAM   = 3'h1,
        OP_ID_ENTER  = 3'h2,
        OP_ID_EXIT   = 3'h3,
        OP_LOCK_LOW  = 3'h4,
        OP_LOCK_HIGH = 3'h5
    } op_e;

endpackage

// ===== flash_bus_cycle.sv
// one timed read or write strobe cycle on the flash pins
`timescale 1ns/1ps
module flash_bus_cycle
(
    // clock and reset
    input  wire logic                                ref_clk,
    input  wire logic                                rstn,
    // request
    input  wire logic                                start,
    input  wire logic                                is_write,
    input  wire logic [flash_host_pkg::ADDR_W-1:0]   addr,
    input  wire logic [flash_host_pkg::DATA_W-1:0]   wdata,
    output logic                                     idle,
    output logic                                     done,
    output logic      [flash_host_pkg::DATA_W-1:0]   rdata,
    // flash pins
    output logic      [flash_host_pkg::ADDR_W-1:0]   flash_addr,
    output logic                                     flash_ce_n,
    output logic                                     flash_oe_n,
    output logic                                     flash_we_n,
    output logic      [flash_host_pkg::DATA_W-1:0]   flash_dq_out,
    output logic                                     flash_dq_oe_n,
    input  wire logic [flash_host_pkg::DATA_W-1:0]   flash_dq_in
);
    import flash_host_pkg::*;

    typedef enum logic [3:0] {
        B_IDLE    = 4'b0001,
        B_SETUP   = 4'b0010,
        B_STROBE  = 4'b0100,
        B_RECOVER = 4'b1000
    } bus_state_e;

    localparam int CNT_W = 5;

    if (RD_CYC >= (1 << CNT_W) || REC_CYC >= (1 << CNT_W)) begin : g_chk
        $error("strobe counts exceed counter width");
    end

    bus_state_e              state, next_state;
    logic [CNT_W-1:0]        cnt, next_cnt;
    logic                    wr, next_wr;
    logic [ADDR_W-1:0]       next_addr;
    logic [DATA_W-1:0]       next_dq_out, next_rdata;
    logic [DATA_W-1:0]       dq_meta, dq_sync;

    always_comb
    begin
        next_state  = state;
        next_cnt    = cnt;
        next_wr     = wr;
        next_addr   = flash_addr;
        next_dq_out = flash_dq_out;
        next_rdata  = rdata;
        unique case (state)
            B_IDLE:
                if (start)
                begin
                    next_state  = B_SETUP;
                    next_wr     = is_write;
                    next_addr   = addr;
                    next_dq_out = wdata;
                end
            B_SETUP:
            begin
                next_state = B_STROBE;
                next_cnt   = wr ? CNT_W'(WP_CYC - 1) : CNT_W'(RD_CYC - 1);
            end
            B_STROBE:
                if (cnt == '0)
                begin
                    next_state = B_RECOVER;
                    next_cnt   = CNT_W'(REC_CYC - 1);
                    if (!wr)
                        next_rdata = dq_sync;
                end
                else
                    next_cnt = cnt - 1'b1;
            B_RECOVER:
                if (cnt == '0)
                    next_state = B_IDLE;
                else
                    next_cnt = cnt - 1'b1;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            state        <= B_IDLE;
            cnt          <= '0;
            wr           <= 1'b0;
            flash_addr   <= '0;
            flash_dq_out <= '0;
            rdata        <= '0;
            dq_meta      <= '0;
            dq_sync      <= '0;
        end
        else
        begin
            state        <= next_state;
            cnt          <= next_cnt;
            wr           <= next_wr;
            flash_addr   <= next_addr;
            flash_dq_out <= next_dq_out;
            rdata        <= next_rdata;
            dq_meta      <= flash_dq_in;
            dq_sync      <= dq_meta;
        end
    end

    // output gate held high on writes, data driven only on writes
    assign idle          = (state == B_IDLE);
    assign done          = (state == B_RECOVER) && (cnt == '0);
    assign flash_ce_n    = !((state == B_SETUP) || (state == B_STROBE));
    assign flash_we_n    = !((state == B_STROBE) && wr);
    assign flash_oe_n    = !((state == B_STROBE) && !wr);
    assign flash_dq_oe_n = !(wr && (state != B_IDLE));

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    AST_OE_HIGH_ON_WRITE: assert property (!flash_we_n |-> flash_oe_n)
        else $error("output gate low during write strobe");
    AST_NO_DRIVE_ON_READ: assert property (!flash_oe_n |-> flash_dq_oe_n && !flash_ce_n)
        else $error("host drives data while device drives");
    AST_WRITE_PULSE: assert property ($fell(flash_we_n) |-> !flash_we_n [*8])
        else $error("write pulse too short");

endmodule

// ===== flash_model.sv
// behavioural sector flash facing the host controller
`timescale 1ns/1ps
module flash_model
#(
    parameter int         WIN_NS  = 600,
    parameter int         PROG_NS = 20000,
    parameter logic [7:0] MAKER   = 8'h5a, // arbitrary
    parameter logic [7:0] PART    = 8'hc3  // arbitrary
)
(
    // pins
    input  wire logic [16:0] addr,
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic [7:0]  dq,
    output logic      [7:0]  q,
    output logic             q_en
);
    logic [7:0]  mem [int];
    logic [7:0]  pend [int];
    logic [22:0] h [6] = '{default: '0};
    logic        loading = 0, busy = 0, tog = 0, lk_lo = 0, lk_hi = 0;
    logic        idm = 0;
    logic [9:0]  sec;
    realtime     last;
    always @(posedge (we_n | ce_n)) if (oe_n && !busy)
    begin
        h = '{h[1], h[2], h[3], h[4], h[5], {addr[14:0], dq}};
        if (loading)
        begin
            pend[addr[6:0]] = dq;
            sec = addr[16:7];
            last = $realtime;
        end
        else if (h[3] == 23'h5555aa && h[4] == 23'h2aaa55 && h[5][22:8] == 15'h5555)
        begin
            if (h[5][7:0] == 8'ha0)
            begin
                loading = 1;
                last = $realtime;
                pend.delete();
            end
            if (h[5][7:0] == 8'h90) idm = 1;
            if (h[5][7:0] == 8'hf0) idm = 0;
            if (h[0] == 23'h5555aa && h[1] == 23'h2aaa55 && h[2] == 23'h555580)
            begin
                if (h[5][7:0] == 8'h40) lk_lo = 1;
                if (h[5][7:0] == 8'h60) lk_hi = 1;
            end
        end
    end
    always #20 if (loading && $realtime - last > WIN_NS)
    begin
        loading = 0;
        busy = 1;
        #PROG_NS;
        if (!(sec < 10'h040 && lk_lo) && !(sec >= 10'h3c0 && lk_hi))
            for (int i = 0; i < 128; i++)
                mem[{sec, 7'(i)}] = pend.exists(i) ? pend[i] : 8'hxx;
        busy = 0;
    end
    always @(negedge (oe_n | ce_n)) if (busy) tog = ~tog;
    assign q_en = !ce_n && !oe_n && we_n;
    always @*
        if (busy) q = {1'b0, tog, 6'h00};
        else if (idm && addr[16:1] == 16'h0) q = addr[0] ? PART : MAKER;
        else q = mem.exists(addr) ? mem[addr] : 8'hff;
endmodule

// ===== sector_flash_program_control_bench.sv
// self-checking bench for the sector flash host controller
`timescale 1ns/1ps
module sector_flash_program_control_bench;
    import flash_host_pkg::*;
    localparam logic [7:0] MAKER = 8'h5a; // arbitrary
    localparam logic [7:0] PART  = 8'hc3; // arbitrary
    logic ref_clk, rstn, cmd_valid, byte_valid, cmd_ready, byte_ready, rsp_valid, rsp_error;
    logic flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe_n, q_en, e;
    logic [ADDR_W-1:0] cmd_addr, flash_addr, a;
    logic [7:0] byte_data, rsp_data, flash_dq_out, flash_dq_in, q, d;
    logic [7:0] sh [int];
    op_e cmd_op;
    int n_errors = 0, n_tests = 0, s;
    assign flash_dq_in = !flash_dq_oe_n ? flash_dq_out : q_en ? q : ~q;
    sector_flash_program_control #(.BLC_LIMIT(200), .WC_LIMIT(2000)) uut (.ref_clk, .rstn, .cmd_valid,
        .cmd_ready, .cmd_op, .cmd_addr, .byte_valid, .byte_ready, .byte_data, .rsp_valid, .rsp_error,
        .rsp_data, .flash_addr, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_dq_out, .flash_dq_oe_n,
        .flash_dq_in);
    flash_model #(.WIN_NS(4800), .MAKER(MAKER), .PART(PART)) dev (.addr(flash_addr), .ce_n(flash_ce_n),
        .oe_n(flash_oe_n), .we_n(flash_we_n), .dq(flash_dq_in), .q, .q_en);
    function automatic logic [7:0] exp_rd(input logic [16:0] x);
        return sh.exists(x) ? sh[x] : 8'hff;
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic run(input op_e op, input logic [16:0] ad, input int nb, input bit keep);
        int i;
        @(negedge ref_clk);
        cmd_valid = 1;
        cmd_op = op;
        cmd_addr = ad;
        while (!cmd_ready) @(negedge ref_clk);
        @(negedge ref_clk);
        cmd_valid = 0;
        for (i = 0; i < nb; i++)
        begin
            repeat ((i == 5) ? 150 : $urandom_range(3, 1)) @(negedge ref_clk);
            byte_valid = 1;
            byte_data = 8'($urandom);
            if (keep) sh[{ad[16:7], 7'(i)}] = byte_data;
            while (!byte_ready) @(negedge ref_clk);
            @(negedge ref_clk);
            byte_valid = 0;
        end
        for (i = 0; i < 5000 && !rsp_valid; i++) @(negedge ref_clk);
        d = rsp_data;
        e = rsp_error;
        if (!rsp_valid) n_errors++;
    endtask
    initial
    begin
        ref_clk = 0;
        forever #10 ref_clk = ~ref_clk;
    end
    initial
    begin
        #1_500_000;
        n_errors++;
        stop_test;
    end
    initial
    begin
        {rstn, cmd_valid, byte_valid, cmd_addr, byte_data} = '0;
        cmd_op = OP_READ;
        s = $urandom(32'h516e);
        repeat (8) @(negedge ref_clk);
        check({flash_ce_n, flash_we_n, flash_oe_n, flash_dq_oe_n, 3'h0, cmd_ready}, 8'hf1);
        rstn = 1;
        s = 64 + $urandom_range(895);
        run(OP_PROGRAM, {s[9:0], 7'h0}, 128, 1);
        check({7'h0, e}, 8'h00);
        run(OP_PROGRAM, {s[9:0] + 10'h1, 7'h0}, 128, 1);
        check({7'h0, e}, 8'h00);
        repeat (12)
        begin
            a = {s[9:0] + 10'($urandom_range(1)), 7'($urandom)};
            run(OP_READ, a, 0, 0);
            check(d, exp_rd(a));
        end
        run(OP_ID_ENTER, 17'h0, 0, 0);
        run(OP_READ, 17'h0, 0, 0);
        check(d, MAKER);
        run(OP_READ, 17'h1, 0, 0);
        check(d, PART);
        run(OP_ID_EXIT, 17'h0, 0, 0);
        a = {s[9:0], 7'h1};
        run(OP_READ, a, 0, 0);
        check(d, exp_rd(a));
        run(OP_LOCK_LOW, 17'h0, 0, 0);
        run(OP_PROGRAM, 17'h00080, 128, 0);
        run(OP_READ, 17'h00085, 0, 0);
        check(d, 8'hff);
        run(OP_LOCK_HIGH, 17'h0, 0, 0);
        run(OP_PROGRAM, 17'h1ff80, 128, 0);
        run(OP_READ, 17'h1ff81, 0, 0);
        check(d, 8'hff);
        run(OP_PROGRAM, {s[9:0] + 10'h2, 7'h0}, 3, 0);
        check({7'h0, e}, 8'h01);
        stop_test;
    end
endmodule
